// File: logic/spf_pkg.sv
// shared constants for the serial peripheral unit with byte fifos
package spf_pkg;

    // register addresses on the cpu bus
    localparam logic [7:0] ADDR_CONTROL    = 8'h98; // serial_port_control
    localparam logic [7:0] ADDR_STATUS     = 8'h99; // serial_port_status, read only
    localparam logic [7:0] ADDR_TX_DATA    = 8'h9a; // write pushes the transmit fifo
    localparam logic [7:0] ADDR_RX_DATA    = 8'h9b; // read pops the receive fifo
    localparam logic [7:0] ADDR_PIN_SELECT = 8'h9c; // expander_pin_select

    // control register fields
    localparam int CTL_RX_IRQ_EN  = 7; // rx_irq_enable
    localparam int CTL_TX_IRQ_EN  = 6; // tx_buffer_irq_enable
    localparam int CTL_EXP_EN     = 5; // select_expander_enable
    localparam int CTL_MODE_HI    = 4; // role_and_rate_field msb
    localparam int CTL_MODE_LO    = 3; // role_and_rate_field lsb
    localparam int CTL_EDGE_SEL   = 2; // clock_edge_select
    localparam int CTL_IF_EN      = 1; // interface_enable
    localparam int CTL_LOOPBACK   = 0; // loopback_enable

    // status register fields
    localparam int STS_RX_OVERRUN = 7;
    localparam int STS_RX_NONEMPTY = 6;
    localparam int STS_TX_FULL    = 5;
    localparam int STS_TX_EMPTY   = 4;
    localparam int STS_TX_FLUSH   = 3;
    localparam int STS_EXP_DET    = 2;

    // reset values
    localparam logic [7:0] CONTROL_RESET    = 8'h00;
    localparam logic [7:0] PIN_SELECT_RESET = 8'h00;
    localparam logic [7:0] EXPANDER_IDLE    = 8'hff; // expander outputs inactive
    localparam logic [7:0] TX_FILLER        = 8'hff; // sent when nothing is queued

    // role and rate codes
    localparam logic [1:0] MODE_SLAVE   = 2'b00;
    localparam logic [1:0] MODE_DIV10   = 2'b01;
    localparam logic [1:0] MODE_DIV40   = 2'b10;
    localparam logic [1:0] MODE_DIV160  = 2'b11;

    // serial clock division ratios and the derived half periods in clocks
    localparam int DIV_FAST   = 10;
    localparam int DIV_MID    = 40;
    localparam int DIV_SLOW   = 160;
    localparam logic [7:0] HALF_FAST = 8'(DIV_FAST / 2);
    localparam logic [7:0] HALF_MID  = 8'(DIV_MID / 2);
    localparam logic [7:0] HALF_SLOW = 8'(DIV_SLOW / 2);

    // framing
    localparam int BYTE_BITS = 8;
    localparam int FRAME_BYTES = 12;
    localparam int FIFO_DEPTH = 12;
    localparam logic [2:0] LAST_BIT = 3'(BYTE_BITS - 1);
    localparam logic [3:0] FRAME_LIMIT = 4'(FRAME_BYTES);

    // master frame sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } spf_state_type;

endpackage

// File: logic/spf_unit.sv
// serial peripheral unit: master or slave shifter, byte fifos, select expander
`timescale 1ns/100ps
`default_nettype none

// byte fifo with valid and ready on both sides
module spf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_rstn,
    input  wire logic             i_clear,
    // filling side
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    // draining side
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];  // storage words
    logic [AW-1:0]    wr_ptr_r;     // next slot to write
    logic [AW-1:0]    rd_ptr_r;     // oldest word
    logic [AW:0]      count_r;      // words held
    logic             push;
    logic             pop;

    // pointer step with wrap at depth
    function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
        step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign o_in_ready  = (count_r != (AW+1)'(DEPTH));
    assign o_out_valid = (count_r != '0);
    assign o_out_data  = mem[rd_ptr_r];
    assign push        = i_in_valid & o_in_ready;
    assign pop         = i_out_ready & o_out_valid;

    // storage write
    always_ff @(posedge i_clock)
    begin
        if (push)
        begin
            mem[wr_ptr_r] <= i_in_data;
        end
    end

    // pointers and fill count; clear empties at once
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end
        else if (i_clear)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= step(wr_ptr_r);
            if (pop)
                rd_ptr_r <= step(rd_ptr_r);
            if (push & !pop)
                count_r <= count_r + 1'b1;
            else if (pop & !push)
                count_r <= count_r - 1'b1;
        end
    end
endmodule // spf_fifo

module spf_unit (
    // clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_rstn,
    // cpu register port
    input  wire logic [7:0] i_bus_addr,
    input  wire logic       i_bus_wr,
    input  wire logic       i_bus_rd,
    input  wire logic [7:0] i_bus_wdata,
    output logic      [7:0] o_bus_rdata,
    output logic            o_tx_ready,
    // serial clock pin
    input  wire logic       i_sck,
    output logic            o_sck,
    output logic            o_sck_oe,
    // slave select pin, active low
    input  wire logic       i_ss_n,
    output logic            o_ss_n,
    output logic            o_ss_n_oe,
    // master out slave in pin
    input  wire logic       i_mosi,
    output logic            o_mosi,
    output logic            o_mosi_oe,
    // master in slave out pin
    input  wire logic       i_miso,
    output logic            o_miso,
    output logic            o_miso_oe,
    // port n: general io value and pin level
    input  wire logic [7:0] i_port_n_gpio,
    output logic      [7:0] o_port_n,
    // interrupt requests
    output logic            o_rx_irq,
    output logic            o_tx_irq
);
    logic [7:0]  control_r;      // serial_port_control
    logic [7:0]  pin_select_r;   // expander_pin_select
    logic [7:0]  expander_r;     // expanded_slave_select levels
    spf_pkg::spf_state_type state_r; // master sequencer
    logic [7:0]  div_r;          // master half period counter
    logic        sck_r;          // master serial clock level
    logic        ss_out_r;       // master select level
    logic        stop_r;         // master has no further byte
    logic        ss_prev_r;      // slave select last cycle
    logic        sck_prev_r;     // slave clock last cycle
    logic        in_frame_r;     // a frame is open
    logic [7:0]  tx_sh_r;        // outgoing bits
    logic [7:0]  rx_sh_r;        // incoming bits
    logic        out_bit_r;      // bit on the data output
    logic [2:0]  bits_r;         // bits sampled in this byte
    logic [3:0]  bytes_r;        // bytes loaded in this frame
    logic        exp_mode_r;     // frame programs the expander
    logic        exp_done_r;     // expander already programmed
    logic        overrun_r;      // receive overrun, sticky
    logic        flush_r;        // transmit flush, sticky
    logic        exp_det_r;      // expander programmed, sticky
    logic        en_prev_r;      // enable last cycle

    // control field views
    logic        en;
    logic        master;
    logic        clock_edge_select;
    logic [1:0]  mode;
    // fifo handshakes
    logic        tx_push;
    logic        tx_in_ready;
    logic        tx_valid;
    logic        tx_pop;
    logic        tx_clear;
    logic [7:0]  tx_data;
    logic        rx_push;
    logic        rx_in_ready;
    logic        rx_valid;
    logic        rx_pop;
    logic [7:0]  rx_data;
    // sequencing strobes
    logic        tick;
    logic        mst_start;
    logic        mst_end;
    logic        frame_start;
    logic        frame_end;
    logic        rise;
    logic        fall;
    logic        sample;
    logic        shift;
    logic        din;
    logic        complete;
    logic        more;
    logic [7:0]  rx_byte;
    logic        status_rd;
    logic [7:0]  status;

    // half period of the master clock for a rate code
    function automatic logic [7:0] half_of(input logic [1:0] m);
        unique case (m)
            spf_pkg::MODE_DIV10:  half_of = spf_pkg::HALF_FAST;
            spf_pkg::MODE_DIV40:  half_of = spf_pkg::HALF_MID;
            default:              half_of = spf_pkg::HALF_SLOW;
        endcase
    endfunction

    assign en     = control_r[spf_pkg::CTL_IF_EN];
    assign mode   = control_r[spf_pkg::CTL_MODE_HI:spf_pkg::CTL_MODE_LO];
    assign master = (mode != spf_pkg::MODE_SLAVE);
    assign clock_edge_select    = control_r[spf_pkg::CTL_EDGE_SEL];

    // master sequencing
    assign tick      = (div_r == half_of(mode) - 8'h01);
    assign mst_start = en & master & (state_r == spf_pkg::ST_IDLE) & tx_valid;
    assign mst_end   = (state_r == spf_pkg::ST_RUN) & tick & !sck_r & stop_r;

    // frame boundaries for either role
    assign frame_start = en & (master ? mst_start : (!i_ss_n & ss_prev_r));
    assign frame_end   = en & in_frame_r & (master ? mst_end : (i_ss_n & !ss_prev_r));

    // clock edges: own divider in master, sampled pin in slave
    assign rise = master ? ((state_r == spf_pkg::ST_RUN) & tick & !sck_r & !stop_r)
                         : (en & in_frame_r & i_sck & !sck_prev_r);
    assign fall = master ? ((state_r == spf_pkg::ST_RUN) & tick & sck_r)
                         : (en & in_frame_r & !i_sck & sck_prev_r);
    assign sample = clock_edge_select ? fall : rise;
    assign shift  = clock_edge_select ? rise : fall;

    // data input, folded back from our own output in loopback
    assign din = control_r[spf_pkg::CTL_LOOPBACK] ? out_bit_r
                                                  : (master ? i_miso : i_mosi);

    // byte completion and next-byte decision
    assign complete = sample & (bits_r == spf_pkg::LAST_BIT);
    assign rx_byte  = {rx_sh_r[6:0], din};
    assign more     = tx_valid & (bytes_r != spf_pkg::FRAME_LIMIT);
    assign tx_pop   = (frame_start & tx_valid) | (complete & more);
    assign tx_clear = frame_end & (tx_valid | (bits_r != 3'h0));
    assign rx_push  = complete & !exp_mode_r;

    // cpu side of the fifos
    assign tx_push   = i_bus_wr & (i_bus_addr == spf_pkg::ADDR_TX_DATA);
    assign rx_pop    = i_bus_rd & (i_bus_addr == spf_pkg::ADDR_RX_DATA);
    assign status_rd = i_bus_rd & (i_bus_addr == spf_pkg::ADDR_STATUS);

    // status view
    always_comb
    begin
        status = 8'h00;
        status[spf_pkg::STS_RX_OVERRUN]  = overrun_r;
        status[spf_pkg::STS_RX_NONEMPTY] = rx_valid;
        status[spf_pkg::STS_TX_FULL]     = !tx_in_ready;
        status[spf_pkg::STS_TX_EMPTY]    = !tx_valid;
        status[spf_pkg::STS_TX_FLUSH]    = flush_r;
        status[spf_pkg::STS_EXP_DET]     = exp_det_r;
    end

    // transmit fifo, filled by the cpu and drained by the shifter
    spf_fifo #(.WIDTH(8), .DEPTH(spf_pkg::FIFO_DEPTH)) u_tx_fifo (
        .i_clock     (i_clock),
        .i_rstn      (i_rstn),
        .i_clear     (tx_clear),
        .i_in_valid  (tx_push),
        .o_in_ready  (tx_in_ready),
        .i_in_data   (i_bus_wdata),
        .o_out_valid (tx_valid),
        .i_out_ready (tx_pop),
        .o_out_data  (tx_data)
    );

    // receive fifo, filled by the shifter and drained by the cpu
    spf_fifo #(.WIDTH(8), .DEPTH(spf_pkg::FIFO_DEPTH)) u_rx_fifo (
        .i_clock     (i_clock),
        .i_rstn      (i_rstn),
        .i_clear     (1'b0),
        .i_in_valid  (rx_push),
        .o_in_ready  (rx_in_ready),
        .i_in_data   (rx_byte),
        .o_out_valid (rx_valid),
        .i_out_ready (rx_pop),
        .o_out_data  (rx_data)
    );

    // software writable registers
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            control_r    <= spf_pkg::CONTROL_RESET;
            pin_select_r <= spf_pkg::PIN_SELECT_RESET;
        end
        else if (i_bus_wr)
        begin
            if (i_bus_addr == spf_pkg::ADDR_CONTROL)
                control_r <= i_bus_wdata;
            if (i_bus_addr == spf_pkg::ADDR_PIN_SELECT)
                pin_select_r <= i_bus_wdata;
        end
    end

    // read data, one cycle after the read strobe
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
            o_bus_rdata <= 8'h00;
        else if (i_bus_rd)
        begin
            unique case (i_bus_addr)
                spf_pkg::ADDR_CONTROL:    o_bus_rdata <= control_r;
                spf_pkg::ADDR_STATUS:     o_bus_rdata <= status;
                spf_pkg::ADDR_RX_DATA:    o_bus_rdata <= rx_valid ? rx_data : 8'h00;
                spf_pkg::ADDR_PIN_SELECT: o_bus_rdata <= pin_select_r;
                default:                  o_bus_rdata <= 8'h00;
            endcase
        end
    end

    // master sequencer: opens a frame when data waits, closes when drained or at the frame byte limit
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_r  <= spf_pkg::ST_IDLE;
            div_r    <= 8'h00;
            sck_r    <= 1'b0;
            ss_out_r <= 1'b1;
        end
        else if (!en || !master)
        begin
            // leaving master role aborts any frame
            state_r  <= spf_pkg::ST_IDLE;
            div_r    <= 8'h00;
            sck_r    <= 1'b0;
            ss_out_r <= 1'b1;
        end
        else
        begin
            unique case (state_r)
                spf_pkg::ST_IDLE:
                begin
                    div_r <= 8'h00;
                    if (mst_start)
                    begin
                        state_r  <= spf_pkg::ST_RUN;
                        ss_out_r <= 1'b0;
                    end
                end
                spf_pkg::ST_RUN:
                begin
                    div_r <= tick ? 8'h00 : div_r + 8'h01;
                    if (mst_end)
                    begin
                        state_r  <= spf_pkg::ST_IDLE;
                        ss_out_r <= 1'b1;
                    end
                    else if (tick)
                        sck_r <= ~sck_r;
                end
            endcase
        end
    end

    // slave pin history for edge detection
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ss_prev_r  <= 1'b1;
            sck_prev_r <= 1'b0;
            en_prev_r  <= 1'b0;
        end
        else
        begin
            ss_prev_r  <= i_ss_n;
            sck_prev_r <= i_sck;
            en_prev_r  <= en;
        end
    end

    // frame tracking
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
            in_frame_r <= 1'b0;
        else if (!en)
            in_frame_r <= 1'b0;
        else if (frame_start)
            in_frame_r <= 1'b1;
        else if (frame_end)
            in_frame_r <= 1'b0;
    end

    // shift engine: load, shift out, sample in
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            tx_sh_r   <= 8'h00;
            rx_sh_r   <= 8'h00;
            out_bit_r <= 1'b1;
            bits_r    <= 3'h0;
            bytes_r   <= 4'h0;
            stop_r    <= 1'b0;
        end
        else if (frame_start)
        begin
            // first byte: present msb now when shifting out on falling edges
            bits_r  <= 3'h0;
            bytes_r <= tx_valid ? 4'h1 : 4'h0;
            stop_r  <= 1'b0;
            if (!clock_edge_select)
            begin
                out_bit_r <= tx_valid ? tx_data[7] : spf_pkg::TX_FILLER[7];
                tx_sh_r   <= tx_valid ? {tx_data[6:0], 1'b0} : spf_pkg::TX_FILLER;
            end
            else
                tx_sh_r <= tx_valid ? tx_data : spf_pkg::TX_FILLER;
        end
        else if (sample)
        begin
            rx_sh_r <= rx_byte;
            bits_r  <= bits_r + 3'h1;
            if (complete)
            begin
                // next byte waits for the following shift edge
                if (more)
                begin
                    tx_sh_r <= tx_data;
                    bytes_r <= bytes_r + 4'h1;
                end
                else
                begin
                    tx_sh_r <= spf_pkg::TX_FILLER;
                    stop_r  <= 1'b1;
                end
            end
        end
        else if (shift)
        begin
            out_bit_r <= tx_sh_r[7];
            tx_sh_r   <= {tx_sh_r[6:0], 1'b0};
        end
    end

    // select expander: arm at frame start, program once, release at end
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            expander_r <= spf_pkg::EXPANDER_IDLE;
            exp_mode_r <= 1'b0;
            exp_done_r <= 1'b0;
        end
        else if (en & !en_prev_r)
        begin
            expander_r <= spf_pkg::EXPANDER_IDLE;
            exp_mode_r <= 1'b0;
            exp_done_r <= 1'b0;
        end
        else if (frame_start)
        begin
            exp_mode_r <= !master & control_r[spf_pkg::CTL_EXP_EN] & !i_mosi;
            exp_done_r <= 1'b0;
        end
        else if (frame_end | !en)
        begin
            if (exp_mode_r)
                expander_r <= spf_pkg::EXPANDER_IDLE;
            exp_mode_r <= 1'b0;
        end
        else if (complete & exp_mode_r & !exp_done_r)
        begin
            expander_r <= rx_byte;
            exp_done_r <= 1'b1;
        end
    end

    // sticky status flags; a new event beats a clearing read
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            overrun_r <= 1'b0;
            flush_r   <= 1'b0;
            exp_det_r <= 1'b0;
        end
        else
        begin
            overrun_r <= (rx_push & !rx_in_ready) | (overrun_r & !status_rd);
            flush_r   <= tx_clear | (flush_r & !status_rd);
            exp_det_r <= (complete & exp_mode_r & !exp_done_r) | (exp_det_r & !status_rd);
        end
    end

    // pins: driven only while enabled, in the role that owns them
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_sck     <= 1'b0;
            o_sck_oe  <= 1'b0;
            o_ss_n    <= 1'b1;
            o_ss_n_oe <= 1'b0;
            o_mosi    <= 1'b1;
            o_mosi_oe <= 1'b0;
            o_miso    <= 1'b1;
            o_miso_oe <= 1'b0;
        end
        else
        begin
            o_sck     <= sck_r;
            o_sck_oe  <= en & master;
            o_ss_n    <= ss_out_r;
            o_ss_n_oe <= en & master;
            o_mosi    <= out_bit_r;
            o_mosi_oe <= en & master;
            o_miso    <= out_bit_r;
            o_miso_oe <= en & !master & in_frame_r;
        end
    end

    // port n mux, interrupt requests and transmit readiness
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_port_n   <= 8'h00;
            o_rx_irq   <= 1'b0;
            o_tx_irq   <= 1'b0;
            o_tx_ready <= 1'b0;
        end
        else
        begin
            o_port_n   <= (pin_select_r & expander_r) | (~pin_select_r & i_port_n_gpio);
            o_rx_irq   <= control_r[spf_pkg::CTL_RX_IRQ_EN] & (rx_valid | overrun_r);
            o_tx_irq   <= control_r[spf_pkg::CTL_TX_IRQ_EN] & !tx_valid;
            o_tx_ready <= tx_in_ready;
        end
    end
endmodule // spf_unit

`default_nettype wire

// File: verif/spf_monitor.sv
// port checker for the serial unit
`timescale 1ns/100ps
`default_nettype none
module spf_monitor (
    input wire logic       i_clock, i_rstn, i_bus_wr, i_bus_rd,
    input wire logic [7:0] i_bus_addr, i_bus_wdata, o_bus_rdata,
    input wire logic       o_sck, o_sck_oe, o_ss_n, o_ss_n_oe,
    input wire logic       o_mosi_oe, o_miso_oe, o_rx_irq, o_tx_irq
);
    logic [7:0] c, d; // control shadow and its copy one cycle older
    always_ff @(posedge i_clock or negedge i_rstn)
        if (!i_rstn) c <= 8'h00;
        else if (i_bus_wr && i_bus_addr == spf_pkg::ADDR_CONTROL) c <= i_bus_wdata;
    always_ff @(posedge i_clock or negedge i_rstn)
        if (!i_rstn) d <= 8'h00;
        else d <= c;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    a_slave_no_drive: assert property
        (c[4:3] == 2'b00 && d[4:3] == 2'b00 |-> !o_sck_oe && !o_ss_n_oe) else $error("slave drives");
    a_master_data_out: assert property
        (c[1] && d[1] && c[4:3] != 2'b00 && d[4:3] != 2'b00 |-> o_mosi_oe) else $error("no mosi drive");
    a_disabled_quiet: assert property
        (!c[1] && !d[1] |-> !(o_sck_oe | o_ss_n_oe | o_mosi_oe | o_miso_oe)) else $error("pins held");
    a_sck_idle_low: assert property
        (o_ss_n_oe && o_ss_n |-> !o_sck) else $error("clock outside frame");
    a_sck_half_rate: assert property
        (c[4:3] == 2'b01 && d[4:3] == 2'b01 && !o_ss_n && $changed(o_sck) |=> $stable(o_sck) [*4])
        else $error("clock half period short");
    a_rx_irq_gate: assert property
        (!c[7] && !d[7] |-> !o_rx_irq) else $error("rx irq while off");
    a_tx_irq_gate: assert property
        (!c[6] && !d[6] |-> !o_tx_irq) else $error("tx irq while off");
    a_ctl_read_back: assert property
        (i_bus_rd && !i_bus_wr && i_bus_addr == spf_pkg::ADDR_CONTROL |=> o_bus_rdata == d)
        else $error("control read differs");
    c_frame: cover property ($fell(o_ss_n));
    c_rx_irq: cover property ($rose(o_rx_irq));
    c_tx_irq: cover property ($rose(o_tx_irq));
endmodule // spf_monitor
bind spf_unit spf_monitor MON (.i_clock, .i_rstn, .i_bus_wr, .i_bus_rd, .i_bus_addr,
    .i_bus_wdata, .o_bus_rdata, .o_sck, .o_sck_oe, .o_ss_n, .o_ss_n_oe, .o_mosi_oe,
    .o_miso_oe, .o_rx_irq, .o_tx_irq);
`default_nettype wire

// File: verif/spf_peer.sv
// far-end slave device: echoes a counting reply, records what it hears
`timescale 1ns/100ps
`default_nettype none
module spf_peer (
    input wire logic i_sck, i_ss_n, i_mosi, i_sce,
    output logic     o_miso
);
    logic [7:0] tx = 8'h5a, rp = 8'h5a, rx = 8'h00;
    logic [7:0] got [$]; // bytes received, oldest first
    int n = 0;
    initial o_miso = 1'b1;
    always @(negedge i_ss_n) begin n = 0; tx = rp; o_miso = tx[7]; end
    // edge select decides which clock edge samples and which one shifts
    always @(i_sck) if (!i_ss_n) begin
        if (i_sck ^ i_sce) begin // sample edge
            rx = {rx[6:0], i_mosi};
            n++;
            if (n == 8) begin got.push_back(rx); n = 0; rp = rp + 8'h11; tx = rp; end
        end else begin // shift edge; the first one of a byte keeps its msb
            if (n != 0) tx = tx << 1;
            o_miso = tx[7];
        end
    end
    always @(posedge i_ss_n) o_miso = ~o_miso; // released line shows no stale bit
endmodule // spf_peer
`default_nettype wire

// File: verif/tb_top.sv
// self-checking bench for the serial unit
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic i_clock = 0, i_rstn = 0, i_bus_wr = 0, i_bus_rd = 0, s_sck = 0, s_ss = 1, s_mosi = 1;
    logic [7:0] i_bus_addr = '0, i_bus_wdata = '0, i_port_n_gpio = '0, o_bus_rdata, o_port_n, v;
    logic [7:0] rp = 8'h5a, sent [$], sel;
    logic [15:0] sw, sm; // slave phase: mosi stream and queued miso bytes
    logic o_sck, o_sck_oe, o_ss_n, o_ss_n_oe, o_mosi, o_mosi_oe, o_miso, o_miso_oe;
    logic o_rx_irq, o_tx_irq, pmiso, o_tx_ready, psce = 0;
    int n_fail = 0, n_tests = 0, cyc = 0, i, m, nb;
    wire i_sck = o_sck_oe ? o_sck : s_sck;
    wire i_ss_n = o_ss_n_oe ? o_ss_n : s_ss;
    wire i_mosi = o_mosi_oe ? o_mosi : s_mosi;
    wire i_miso = o_miso_oe ? o_miso : pmiso;
    always #4 i_clock = ~i_clock;
    spf_unit DUT (.i_clock, .i_rstn, .i_bus_addr, .i_bus_wr, .i_bus_rd, .i_bus_wdata,
        .o_bus_rdata, .o_tx_ready, .i_sck, .o_sck, .o_sck_oe, .i_ss_n, .o_ss_n, .o_ss_n_oe,
        .i_mosi, .o_mosi, .o_mosi_oe, .i_miso, .o_miso, .o_miso_oe, .i_port_n_gpio, .o_port_n,
        .o_rx_irq, .o_tx_irq);
    spf_peer PEER (.i_sck, .i_ss_n, .i_mosi, .i_sce(psce), .o_miso(pmiso));
    task automatic chk(input logic [7:0] s, e, input string nm);
        n_tests++;
        if (s !== e) begin n_fail++; $display("[FAIL] %s exp %h got %h", nm, e, s); end
    endtask
    task automatic bw(input logic [7:0] a, dv);
        @(negedge i_clock); i_bus_addr = a; i_bus_wdata = dv; i_bus_wr = 1;
        @(negedge i_clock); i_bus_wr = 0;
    endtask
    task automatic br(input logic [7:0] a);
        @(negedge i_clock); i_bus_addr = a; i_bus_rd = 1;
        @(negedge i_clock); i_bus_rd = 0;
    endtask
    task automatic close_out;
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 20000) begin n_fail++; close_out; end
    end
    initial begin
        void'($urandom(32'hf4e0));
        repeat (12) @(negedge i_clock);
        i_rstn = 1; i_port_n_gpio = 8'($urandom);
        br(8'h98); chk(o_bus_rdata, spf_pkg::CONTROL_RESET, "ctl reset");
        v = 8'($urandom) & 8'hfc;
        bw(8'h98, v); br(8'h98); chk(o_bus_rdata, v, "ctl rw");
        for (m = 1; m < 4; m++) begin
            nb = (m == 1) ? 12 : 2; psce = (m == 3);
            bw(8'h98, 8'h00);
            for (i = 0; i < nb; i++) begin v = 8'($urandom); sent.push_back(v); bw(8'h9a, v); end
            // mode 01 plain, mode 10 with loopback, mode 11 on the other clock edge
            bw(8'h98, (m == 1) ? 8'hca : (m == 2) ? 8'hd3 : 8'hde);
            chk(o_tx_ready, (nb < 12) ? 8'h01 : 8'h00, "tx room");
            repeat (2) @(negedge i_clock); chk(i_ss_n, 8'h00, "frame open");
            for (i = 0; i < 9000 && i_ss_n !== 1'b1; i++) @(negedge i_clock);
            chk(i_ss_n, 8'h01, "frame end");
            repeat (4) @(negedge i_clock);
            chk(o_tx_irq, 8'h01, "tx irq");
            chk(o_rx_irq, 8'h01, "rx irq");
            for (i = 0; i < nb; i++) begin
                v = sent.pop_front(); br(8'h9b);
                chk(PEER.got.pop_front(), v, "mosi byte");
                chk(o_bus_rdata, (m == 2) ? v : rp, "rx byte");
                rp = rp + 8'h11;
            end
            repeat (3) @(negedge i_clock); chk(o_rx_irq, 8'h00, "rx irq idle");
        end
        bw(8'h98, 8'h22); sel = 8'($urandom); bw(8'h9c, sel);
        sm = 16'($urandom); bw(8'h9a, sm[15:8]); bw(8'h9a, sm[7:0]);
        repeat (3) @(negedge i_clock);
        chk(o_port_n, sel | i_port_n_gpio, "exp idle");
        sw = 16'($urandom); s_mosi = 0; s_ss = 0;
        for (i = 15; i >= 0; i--) begin
            repeat (5) @(negedge i_clock); s_mosi = sw[i];
            chk({o_miso_oe, o_miso}, {1'b1, sm[i]}, "miso bit");
            repeat (5) @(negedge i_clock); s_sck = 1;
            repeat (5) @(negedge i_clock); s_sck = 0;
        end
        repeat (6) @(negedge i_clock);
        chk(o_port_n, (sel & sw[15:8]) | (~sel & i_port_n_gpio), "exp byte");
        br(8'h9b); chk(o_bus_rdata, 8'h00, "rx discard");
        s_ss = 1; repeat (4) @(negedge i_clock);
        chk(o_port_n, sel | i_port_n_gpio, "exp end");
        close_out;
    end
endmodule // tb_top
`default_nettype wire
